// [hdl/dsulc_consts.svh]
/*
 * offsets, fields, reset values, rates and counts of dsulc_top.
 * assumes a 50 mhz clock and a 32-bit axi4-lite bus.
 */
`ifndef DSULC_CONSTS_SVH
`define DSULC_CONSTS_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define DSULC_CFG_OFS     8'h00
`define DSULC_NET_OFS     8'h04
`define DSULC_CMD_OFS     8'h08
`define DSULC_STAT_OFS    8'h0c
`define DSULC_RATE_OFS    8'h10

// ****************************************************************
// cfg fields
// ****************************************************************
`define DSULC_CFG_MODE    0
`define DSULC_CFG_SWRATE  2:1
`define DSULC_CFG_TIMING  4:3
`define DSULC_CFG_P2PRATE 5
`define DSULC_CFG_TOEN    6
`define DSULC_CFG_SECEN   7
`define DSULC_CFG_DUR     14:8
`define DSULC_CFG_RST     32'h0000_0ae4

// ****************************************************************
// net fields
// ****************************************************************
`define DSULC_NET_NETLB   0
`define DSULC_NET_SCR     1
`define DSULC_NET_V54     2
`define DSULC_NET_MGMT    4:3
`define DSULC_NET_RST     32'h0000_0001

// ****************************************************************
// cmd bits (write one to act)
// ****************************************************************
`define DSULC_CMD_COMMIT  0
`define DSULC_CMD_TSTART  1
`define DSULC_CMD_TSTOP   2
`define DSULC_CMD_SECCLR  3

// ****************************************************************
// rates in bps and timing
// ****************************************************************
`define DSULC_RATE_56K    17'd56000
`define DSULC_RATE_64K    17'd64000
`define DSULC_RATE_72K    17'd72000
`define DSULC_MGMT_1600   17'd1600
`define DSULC_MGMT_4000   17'd4000
`define DSULC_MGMT_8000   17'd8000
`define DSULC_CLK_HZ      50000000
`define DSULC_MINUTE_S    60
`define DSULC_MIN_CYC     (`DSULC_CLK_HZ * `DSULC_MINUTE_S)
`define DSULC_DUR_MIN     7'd1
`define DSULC_DUR_MAX     7'd120

`endif

// [hdl/dsulc_minute_timer.sv]
/*
 * minute counter for the user test timeout.
 * assumes MIN_CYC clocks a minute; simulation shortens it.
 */
`include "dsulc_consts.svh"

module dsulc_minute_timer #(
	parameter int unsigned MIN_CYC = `DSULC_MIN_CYC
) (
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       clear,
	input  wire logic       run,
	output logic      [6:0] minutes_r
);

	logic [31:0] tick_cnt_r;
	logic        tick;

	assign tick = run && (tick_cnt_r == 32'(MIN_CYC - 1));

	// ****************************************************************
	// minute tick from system clock
	// ****************************************************************
	always_ff @(posedge aclk) begin
		if (!aresetn || clear || !run) begin
			tick_cnt_r <= 32'h0;
		end else if (tick) begin
			tick_cnt_r <= 32'h0;
		end else begin
			tick_cnt_r <= tick_cnt_r + 32'h1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || clear) begin
			minutes_r <= 7'h0;
		end else if (tick && minutes_r != 7'h7f) begin
			minutes_r <= minutes_r + 7'h1;
		end
	end

endmodule : dsulc_minute_timer

// [hdl/dsulc_pkg.sv]
/*
 * types of dsulc_top.
 * assumes nothing beyond the importing module.
 */
package dsulc_pkg;

	typedef enum logic [1:0] {
		DSULC_SW_56   = 2'b00,
		DSULC_SW_CLEAR_CHANNEL_64K = 2'b01,
		DSULC_SW_AUTO = 2'b10
	} dsulc_swrate_t;

	typedef enum logic [1:0] {
		DSULC_TM_INT  = 2'b00,
		DSULC_TM_EXT  = 2'b01,
		DSULC_TM_RCV  = 2'b10
	} dsulc_timing_t;

	// gray order along idle -> user test -> timed out
	typedef enum logic [1:0] {
		DSULC_T_IDLE  = 2'b00,
		DSULC_T_USER  = 2'b01,
		DSULC_T_NET   = 2'b10,
		DSULC_T_DONE  = 2'b11
	} dsulc_test_t;

endpackage : dsulc_pkg

// [hdl/dsulc_top.sv]
/*
 * line mode, rate, timing source and dte clock rate,
 * test timing, loopbacks, scrambling and security alarm
 * of a data service unit.
 * assumes line events already on aclk;
 * the dte timing pin is asynchronous.
 */
// Decided for this implementation: the AXI4-Lite interface to the registers and the register addresses.
// Summary of operation
// - two modes; switched network after reset
// - switched network runs 56k or 64k clear
// - auto-detect default, replaced by detected rate
// - clear 64k runs on a 72k circuit
// - dte clocks equal line rate minus mgmt
// - direct internal timing uses local clock
// - direct external timing uses dte clock
// - receive timing, internal during tests; code switches only for user and dte tests, not network loopbacks
// - direct line 56 or 64k, default 64
// - options apply only in their own mode
// - timeout ends user tests after duration
// - timeout off: tests end by stop command
// - timeout ignores dte and network tests
// - duration 1 to 120 minutes, default 10; code takes any value 0 to 127 unchecked
// - security alarm only when enabled
// - network latching loopback when enabled
// - optional scrambling in switched mode
// - v54 loop up and down when enabled
// - mgmt channel off or 1600/4000/8000
// - both ends share mgmt channel rate
`include "dsulc_consts.svh"

module dsulc_top
	import dsulc_pkg::*;
#(
	parameter int unsigned MIN_CYC = `DSULC_MIN_CYC
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        line_signal_found,
	input  wire logic        line_rate_is_64,
	input  wire logic        net_loop_up,
	input  wire logic        net_loop_down,
	input  wire logic        v54_loop_up,
	input  wire logic        v54_loop_down,
	input  wire logic        dte_test_active,
	input  wire logic        access_failed,
	input  wire logic        dte_ext_clk_pin,
	output logic             direct_line_mode_r,
	output logic [16:0]      line_rate_bps_r,
	output logic [16:0]      line_circuit_bps_r,
	output logic             clear_channel_64k_r,
	output logic             rate_detecting_r,
	output logic [16:0]      dte_clock_bps_r,
	output logic [16:0]      inband_mgmt_bps_r,
	output logic [1:0]       timing_src_r,
	output logic             scramble_en_r,
	output logic             dsu_loopback_r,
	output logic             user_test_r,
	output logic             security_alarm_r,
	output logic             dte_ext_clk_sync_r
);

	// ****************************************************************
	// shared functions
	// ****************************************************************
	function automatic logic [16:0] mgmt_bps(input logic [1:0] sel);
		logic [16:0] r;
		r = 17'h0;
		unique case (sel)
			2'b01: r = `DSULC_MGMT_1600;
			2'b10: r = `DSULC_MGMT_4000;
			2'b11: r = `DSULC_MGMT_8000;
			default: r = 17'h0;
		endcase
		return r;
	endfunction : mgmt_bps

	function automatic logic is_ofs(input logic [7:0] a, input logic [7:0] o);
		return a[7:2] == o[7:2];
	endfunction : is_ofs

	// ****************************************************************
	// register state
	// ****************************************************************
	logic [31:0]   cfg_r;
	logic [31:0]   net_r;
	logic          act_mode_r;
	dsulc_swrate_t act_sw_r;
	dsulc_timing_t act_tm_r;
	logic          act_p2p64_r;
	logic [1:0]    act_mgmt_r;
	logic          aw_hold_r;
	logic          w_hold_r;
	logic [7:0]    aw_addr_r;
	logic [31:0]   w_data_r;
	logic [3:0]    w_strb_r;
	logic          dte_ext_meta_r;
	dsulc_test_t   test_st_r;
	logic [6:0]    minutes;
	logic          timed_out_r;
	logic          wr_fire;
	logic [7:0]    wa;
	logic [31:0]   wd;
	logic [3:0]    ws;
	logic          cmd_commit;
	logic          cmd_tstart;
	logic          cmd_tstop;
	logic          cmd_secclr;
	logic          sw_mode;
	logic [6:0]    dur;
	logic          test_any;

	assign wa = aw_hold_r ? aw_addr_r : s_axi_awaddr;
	assign wd = w_hold_r ? w_data_r : s_axi_wdata;
	assign ws = w_hold_r ? w_strb_r : s_axi_wstrb;
	assign s_axi_awready = !aw_hold_r && !s_axi_bvalid;
	assign s_axi_wready  = !w_hold_r && !s_axi_bvalid;
	assign wr_fire = (aw_hold_r || s_axi_awvalid) &&
		(w_hold_r || s_axi_wvalid) && !s_axi_bvalid;
	assign cmd_commit = wr_fire && is_ofs(wa, `DSULC_CMD_OFS) && ws[0] &&
		wd[`DSULC_CMD_COMMIT];
	assign cmd_tstart = wr_fire && is_ofs(wa, `DSULC_CMD_OFS) && ws[0] &&
		wd[`DSULC_CMD_TSTART];
	assign cmd_tstop = wr_fire && is_ofs(wa, `DSULC_CMD_OFS) && ws[0] &&
		wd[`DSULC_CMD_TSTOP];
	assign cmd_secclr = wr_fire && is_ofs(wa, `DSULC_CMD_OFS) && ws[0] &&
		wd[`DSULC_CMD_SECCLR];
	assign sw_mode = !act_mode_r;
	assign dur = cfg_r[`DSULC_CFG_DUR];
	assign test_any = user_test_r || dte_test_active;

	// ****************************************************************
	// axi4-lite write channel: address and data in either order
	// ****************************************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_r <= 1'b0;
			w_hold_r  <= 1'b0;
			aw_addr_r <= 8'h0;
			w_data_r  <= 32'h0;
			w_strb_r  <= 4'h0;
		end else if (wr_fire) begin
			aw_hold_r <= 1'b0;
			w_hold_r  <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_r <= 1'b1;
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= 2'b00;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= (is_ofs(wa, `DSULC_CFG_OFS) ||
				is_ofs(wa, `DSULC_NET_OFS) ||
				is_ofs(wa, `DSULC_CMD_OFS)) ? 2'b00 : 2'b10;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ****************************************************************
	// edit registers: written freely; mode, rates, timing and mgmt wait for commit
	// ****************************************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg_r <= `DSULC_CFG_RST;
			net_r <= `DSULC_NET_RST;
		end else if (wr_fire) begin
			for (int b = 0; b < 4; b++) begin
				if (ws[b] && is_ofs(wa, `DSULC_CFG_OFS)) begin
					cfg_r[8*b +: 8] <= wd[8*b +: 8];
				end
				if (ws[b] && is_ofs(wa, `DSULC_NET_OFS)) begin
					net_r[8*b +: 8] <= wd[8*b +: 8];
				end
			end
		end
	end

	// ****************************************************************
	// committed selections
	// ****************************************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			act_mode_r  <= 1'b0;
			act_sw_r    <= DSULC_SW_AUTO;
			act_tm_r    <= DSULC_TM_INT;
			act_p2p64_r <= 1'b1;
			act_mgmt_r  <= 2'b00;
		end else if (cmd_commit) begin
			act_mode_r  <= cfg_r[`DSULC_CFG_MODE];
			act_p2p64_r <= cfg_r[`DSULC_CFG_P2PRATE];
			act_mgmt_r  <= net_r[`DSULC_NET_MGMT];
			// illegal codes fall back to the defaults
			act_sw_r <= (cfg_r[`DSULC_CFG_SWRATE] == 2'b11) ? DSULC_SW_AUTO :
				dsulc_swrate_t'(cfg_r[`DSULC_CFG_SWRATE]);
			act_tm_r <= (cfg_r[`DSULC_CFG_TIMING] == 2'b11) ? DSULC_TM_INT :
				dsulc_timing_t'(cfg_r[`DSULC_CFG_TIMING]);
		end else if (sw_mode && act_sw_r == DSULC_SW_AUTO &&
			line_signal_found) begin
			act_sw_r <= line_rate_is_64 ? DSULC_SW_CLEAR_CHANNEL_64K : DSULC_SW_56;
		end
	end

	// ****************************************************************
	// line rate, dte clock rate and timing source
	// ****************************************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			direct_line_mode_r  <= 1'b0;
			line_rate_bps_r     <= 17'h0;
			line_circuit_bps_r  <= 17'h0;
			clear_channel_64k_r <= 1'b0;
			rate_detecting_r    <= 1'b1;
			dte_clock_bps_r     <= 17'h0;
			inband_mgmt_bps_r   <= 17'h0;
		end else begin
			direct_line_mode_r <= act_mode_r;
			inband_mgmt_bps_r  <= mgmt_bps(act_mgmt_r);
			if (sw_mode) begin
				rate_detecting_r    <= act_sw_r == DSULC_SW_AUTO;
				clear_channel_64k_r <= act_sw_r == DSULC_SW_CLEAR_CHANNEL_64K;
				unique case (act_sw_r)
					DSULC_SW_56: begin
						line_rate_bps_r    <= `DSULC_RATE_56K;
						line_circuit_bps_r <= `DSULC_RATE_56K;
					end
					DSULC_SW_CLEAR_CHANNEL_64K: begin
						line_rate_bps_r    <= `DSULC_RATE_64K;
						line_circuit_bps_r <= `DSULC_RATE_72K;
					end
					default: begin
						line_rate_bps_r    <= 17'h0;
						line_circuit_bps_r <= 17'h0;
					end
				endcase
			end else begin
				// switched-only rate setting has no effect here
				rate_detecting_r    <= 1'b0;
				clear_channel_64k_r <= 1'b0;
				line_rate_bps_r <= act_p2p64_r ? `DSULC_RATE_64K :
					`DSULC_RATE_56K;
				line_circuit_bps_r <= act_p2p64_r ? `DSULC_RATE_64K :
					`DSULC_RATE_56K;
			end
			// no clock toward the dte while the rate is unknown
			if (sw_mode && act_sw_r == DSULC_SW_AUTO) begin
				dte_clock_bps_r <= 17'h0;
			end else if (sw_mode) begin
				dte_clock_bps_r <= ((act_sw_r == DSULC_SW_CLEAR_CHANNEL_64K) ?
					`DSULC_RATE_64K : `DSULC_RATE_56K) -
					mgmt_bps(act_mgmt_r);
			end else begin
				dte_clock_bps_r <= (act_p2p64_r ? `DSULC_RATE_64K :
					`DSULC_RATE_56K) - mgmt_bps(act_mgmt_r);
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			timing_src_r <= 2'(DSULC_TM_INT);
		end else if (sw_mode) begin
			// switched mode always takes line timing
			timing_src_r <= 2'(DSULC_TM_RCV);
		end else if (act_tm_r == DSULC_TM_RCV && test_any) begin
			timing_src_r <= 2'(DSULC_TM_INT);
		end else begin
			timing_src_r <= 2'(act_tm_r);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dte_ext_meta_r     <= 1'b0;
			dte_ext_clk_sync_r <= 1'b0;
		end else begin
			dte_ext_meta_r     <= dte_ext_clk_pin;
			dte_ext_clk_sync_r <= dte_ext_meta_r;
		end
	end

	// ****************************************************************
	// user test timing
	// ****************************************************************
	dsulc_minute_timer #(
		.MIN_CYC   (MIN_CYC)
	) u_timer (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.clear     (cmd_tstart),
		.run       (user_test_r),
		.minutes_r (minutes)
	);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			user_test_r <= 1'b0;
			timed_out_r <= 1'b0;
		end else if (cmd_tstart) begin
			user_test_r <= 1'b1;
			timed_out_r <= 1'b0;
		end else if (cmd_tstop) begin
			user_test_r <= 1'b0;
		end else if (user_test_r && cfg_r[`DSULC_CFG_TOEN] &&
			minutes >= dur) begin
			// dte and network tests are not in user_test_r
			user_test_r <= 1'b0;
			timed_out_r <= 1'b1;
		end
	end

	// test state kept for status readback
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			test_st_r <= DSULC_T_IDLE;
		end else if (user_test_r) begin
			test_st_r <= DSULC_T_USER;
		end else if (dsu_loopback_r || dte_test_active) begin
			test_st_r <= DSULC_T_NET;
		end else if (timed_out_r) begin
			test_st_r <= DSULC_T_DONE;
		end else begin
			test_st_r <= DSULC_T_IDLE;
		end
	end

	// ****************************************************************
	// loopback responses, scrambling, security alarm
	// ****************************************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dsu_loopback_r <= 1'b0;
		end else if ((sw_mode && net_r[`DSULC_NET_NETLB] && net_loop_down) ||
			(net_r[`DSULC_NET_V54] && v54_loop_down)) begin
			dsu_loopback_r <= 1'b0;
		end else if ((sw_mode && net_r[`DSULC_NET_NETLB] && net_loop_up) ||
			(net_r[`DSULC_NET_V54] && v54_loop_up)) begin
			dsu_loopback_r <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			scramble_en_r <= 1'b0;
		end else begin
			scramble_en_r <= sw_mode && net_r[`DSULC_NET_SCR];
		end
	end

	// set wins over a clear in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			security_alarm_r <= 1'b0;
		end else if (access_failed && cfg_r[`DSULC_CFG_SECEN]) begin
			security_alarm_r <= 1'b1;
		end else if (cmd_secclr) begin
			security_alarm_r <= 1'b0;
		end
	end

	// ****************************************************************
	// axi4-lite read channel
	// ****************************************************************
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0;
			s_axi_rresp  <= 2'b00;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= 2'b00;
			if (is_ofs(s_axi_araddr, `DSULC_CFG_OFS)) begin
				s_axi_rdata <= cfg_r;
			end else if (is_ofs(s_axi_araddr, `DSULC_NET_OFS)) begin
				s_axi_rdata <= net_r;
			end else if (is_ofs(s_axi_araddr, `DSULC_CMD_OFS)) begin
				s_axi_rdata <= 32'h0;
			end else if (is_ofs(s_axi_araddr, `DSULC_STAT_OFS)) begin
				s_axi_rdata <= {12'h0, minutes, test_st_r, timing_src_r,
					security_alarm_r, dsu_loopback_r, scramble_en_r,
					user_test_r, timed_out_r, clear_channel_64k_r,
					rate_detecting_r, direct_line_mode_r};
			end else if (is_ofs(s_axi_araddr, `DSULC_RATE_OFS)) begin
				s_axi_rdata <= {15'h0, dte_clock_bps_r};
			end else begin
				s_axi_rdata <= 32'h0;
				s_axi_rresp <= 2'b10;
			end
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule : dsulc_top

// [verification/dsulc_line_model.sv]
/*
 * far side of dsulc_top: line events and the dte timing pin.
 * assumes its tasks are called from the bench.
 */
module dsulc_line_model (
	input  wire logic aclk,
	output logic      line_signal_found,
	output logic      line_rate_is_64,
	output logic      net_loop_up,
	output logic      net_loop_down,
	output logic      v54_loop_up,
	output logic      v54_loop_down,
	output logic      access_failed,
	output logic      dte_test_active,
	output logic      dte_ext_clk_pin
);
	timeunit 1ns;
	timeprecision 100ps;
	// ****************************************************************
	// events and pin
	// ****************************************************************
	logic [4:0] ev_r;
	logic       ext_run;
	assign {access_failed, v54_loop_down, v54_loop_up, net_loop_down,
		net_loop_up} = ev_r;
	initial begin
		{ev_r, ext_run, line_signal_found} = 7'h00;
		{line_rate_is_64, dte_test_active, dte_ext_clk_pin} = 3'b000;
	end
	task automatic send(input int k);
		@(posedge aclk);
		ev_r <= 5'h01 << k;
		@(posedge aclk);
		ev_r <= 5'h00;
	endtask : send
	task automatic detect(input logic r64);
		@(posedge aclk);
		line_rate_is_64 <= r64;
		line_signal_found <= 1'b1;
	endtask : detect
	// started 1 ns off the aclk grid, so the pin never moves on an edge
	initial begin
		#1;
		forever #12.5 if (ext_run) dte_ext_clk_pin = ~dte_ext_clk_pin;
	end
endmodule : dsulc_line_model

// [verification/dsulc_top_chk.sv]
/*
 * assertions on the ports of dsulc_top.
 * assumes the bind below.
 */
`include "dsulc_consts.svh"

module dsulc_top_chk (
	input logic        aclk,
	input logic        aresetn,
	input logic        line_signal_found,
	input logic        line_rate_is_64,
	input logic        net_loop_up,
	input logic        v54_loop_up,
	input logic        access_failed,
	input logic        dte_ext_clk_pin,
	input logic        direct_line_mode_r,
	input logic [16:0] line_rate_bps_r,
	input logic [16:0] line_circuit_bps_r,
	input logic        clear_channel_64k_r,
	input logic        rate_detecting_r,
	input logic [16:0] dte_clock_bps_r,
	input logic [16:0] inband_mgmt_bps_r,
	input logic        dsu_loopback_r,
	input logic        user_test_r,
	input logic        security_alarm_r,
	input logic        dte_ext_clk_sync_r
);
	// ****************************************************************
	// properties
	// ****************************************************************
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	chk_cc_circuit: assert property (
		clear_channel_64k_r |-> line_circuit_bps_r == `DSULC_RATE_72K)
		else $error("clear channel circuit rate wrong");
	// two-cycle history tolerates a one-edge settle
	chk_dte_rate: assert property (
		!rate_detecting_r && line_rate_bps_r == $past(line_rate_bps_r, 2)
		&& inband_mgmt_bps_r == $past(inband_mgmt_bps_r, 2) |->
		dte_clock_bps_r == 17'(line_rate_bps_r - inband_mgmt_bps_r))
		else $error("dte clock not line minus mgmt");
	chk_mgmt_codes: assert property (
		inband_mgmt_bps_r inside {17'd0, `DSULC_MGMT_1600,
		`DSULC_MGMT_4000, `DSULC_MGMT_8000})
		else $error("mgmt rate outside its codes");
	chk_sw_rates: assert property (
		!direct_line_mode_r && !rate_detecting_r |->
		line_rate_bps_r inside {`DSULC_RATE_56K, `DSULC_RATE_64K})
		else $error("switched line rate illegal");
	chk_auto_detect: assert property (
		rate_detecting_r && line_signal_found && !direct_line_mode_r |-> ##2
		!rate_detecting_r && line_rate_bps_r == ($past(line_rate_is_64) ?
		`DSULC_RATE_64K : `DSULC_RATE_56K))
		else $error("detected rate not taken");
	chk_loop_cause: assert property (
		$rose(dsu_loopback_r) |-> $past(net_loop_up || v54_loop_up))
		else $error("loopback without loop up");
	chk_alarm_cause: assert property (
		$rose(security_alarm_r) |-> $past(access_failed))
		else $error("alarm without failed access");
	chk_pin_sync: assert property (
		dte_ext_clk_sync_r == $past(dte_ext_clk_pin, 2))
		else $error("dte clock pin sync wrong");
	cover property ($rose(dsu_loopback_r));
	cover property ($fell(user_test_r));
	cover property ($fell(rate_detecting_r));
endmodule : dsulc_top_chk

bind dsulc_top dsulc_top_chk chk_u (.*);

// [verification/dsulc_top_tb_top.sv]
/*
 * bench for dsulc_top over axi4-lite and dsulc_line_model.
 * assumes a minute of MIN_CYC cycles.
 */
`include "dsulc_consts.svh"

module dsulc_top_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int unsigned MIN_CYC = 20;
	localparam logic [16:0] MG [4] = '{17'd0, `DSULC_MGMT_1600,
		`DSULC_MGMT_4000, `DSULC_MGMT_8000};
	localparam int   LK [6] = '{0, 1, 2, 0, 2, 3};
	localparam logic LX [6] = '{1, 0, 0, 0, 1, 0};
	logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
	logic        s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, timing_src_r;
	logic        line_signal_found, line_rate_is_64, net_loop_up;
	logic        net_loop_down, v54_loop_up, v54_loop_down, dte_test_active;
	logic        access_failed, dte_ext_clk_pin, direct_line_mode_r;
	logic        clear_channel_64k_r, rate_detecting_r, scramble_en_r;
	logic        dsu_loopback_r, user_test_r, security_alarm_r;
	logic        dte_ext_clk_sync_r;
	logic [16:0] line_rate_bps_r, line_circuit_bps_r, dte_clock_bps_r;
	logic [16:0] inband_mgmt_bps_r, pm;
	int          n_errors, check_count, cyc;

	dsulc_top #(.MIN_CYC(MIN_CYC)) dut_u (.aclk, .aresetn, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.line_signal_found, .line_rate_is_64, .net_loop_up, .net_loop_down,
		.v54_loop_up, .v54_loop_down, .dte_test_active, .access_failed,
		.dte_ext_clk_pin, .direct_line_mode_r, .line_rate_bps_r,
		.line_circuit_bps_r, .clear_channel_64k_r, .rate_detecting_r,
		.dte_clock_bps_r, .inband_mgmt_bps_r, .timing_src_r, .scramble_en_r,
		.dsu_loopback_r, .user_test_r, .security_alarm_r,
		.dte_ext_clk_sync_r);
	dsulc_line_model line_u (.aclk, .line_signal_found, .line_rate_is_64,
		.net_loop_up, .net_loop_down, .v54_loop_up, .v54_loop_down,
		.access_failed, .dte_test_active, .dte_ext_clk_pin);

	// ****************************************************************
	// tasks
	// ****************************************************************
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic finish_test();
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : finish_test
	task automatic tick(input int n);
		repeat (n) @(posedge aclk);
		@(negedge aclk);
	endtask : tick
	// readies are sampled at the falling edge, where nothing moves
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		logic ta, tw, tb;
		logic [1:0] r;
		@(posedge aclk);
		{s_axi_awaddr, s_axi_wdata} <= {a, d};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
		do begin
			@(negedge aclk);
			{ta, tw, tb, r} = {s_axi_awvalid && s_axi_awready,
				s_axi_wvalid && s_axi_wready, s_axi_bvalid, s_axi_bresp};
			@(posedge aclk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
		end while (!tb);
		s_axi_bready <= 1'b0;
		chk(r, er);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] ed,
		input logic [1:0] er);
		logic ta, tb;
		logic [31:0] d;
		logic [1:0] r;
		@(posedge aclk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'b11;
		do begin
			@(negedge aclk);
			{ta, tb, d, r} = {s_axi_arvalid && s_axi_arready,
				s_axi_rvalid, s_axi_rdata, s_axi_rresp};
			@(posedge aclk);
			if (ta) s_axi_arvalid <= 1'b0;
		end while (!tb);
		s_axi_rready <= 1'b0;
		chk(d, ed);
		chk(r, er);
	endtask : rd
	task automatic commit();
		wr(`DSULC_CMD_OFS, 32'h1, 2'b00);
		tick(3);
	endtask : commit

	// ****************************************************************
	// clock, timeout and tests
	// ****************************************************************
	initial begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 8000) begin
			n_errors++;
			finish_test();
		end
	end
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'b000;
		{s_axi_arvalid, s_axi_rready, aresetn} = 3'b000;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		s_axi_wstrb = 4'hf;
		pm = 17'd0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		tick(0);
		chk(rate_detecting_r, 32'h1);
		chk(direct_line_mode_r, 32'h0);
		rd(`DSULC_CFG_OFS, {17'h0, 7'd10, 3'b111, 5'h04}, 2'b00);
		rd(`DSULC_NET_OFS, 32'h1, 2'b00);
		rd(8'h20, 32'h0, 2'b10);
		wr(`DSULC_RATE_OFS, 32'h0, 2'b10);
		line_u.detect(1'b1);
		tick(2);
		chk(line_rate_bps_r, `DSULC_RATE_64K);
		chk(line_circuit_bps_r, `DSULC_RATE_72K);
		chk(clear_channel_64k_r, 32'h1);
		$display("test reset and detect ended");
		wr(`DSULC_CFG_OFS, 32'h0000_0ac0, 2'b00);
		for (int i = 3; i >= 0; i--) begin
			wr(`DSULC_NET_OFS, {27'h0, 2'(i), 3'b011}, 2'b00);
			tick(2);
			chk(inband_mgmt_bps_r, pm);
			commit();
			chk(line_rate_bps_r, `DSULC_RATE_56K);
			chk(inband_mgmt_bps_r, MG[i]);
			chk(dte_clock_bps_r, `DSULC_RATE_56K - MG[i]);
			pm = MG[i];
		end
		chk(scramble_en_r, 32'h1);
		chk(timing_src_r, 32'h2);
		$display("test rates ended");
		for (int j = 0; j < 6; j++) begin
			if (j == 3) wr(`DSULC_NET_OFS, 32'h4, 2'b00);
			line_u.send(LK[j]);
			tick(2);
			chk(dsu_loopback_r, LX[j]);
		end
		line_u.send(4);
		tick(2);
		chk(security_alarm_r, 32'h1);
		wr(`DSULC_CMD_OFS, 32'h8, 2'b00);
		wr(`DSULC_CFG_OFS, 32'h0000_0a40, 2'b00);
		line_u.send(4);
		tick(2);
		chk(security_alarm_r, 32'h0);
		$display("test events ended");
		wr(`DSULC_CFG_OFS, 32'h0000_0ae9, 2'b00);
		tick(2);
		chk(direct_line_mode_r, 32'h0);
		commit();
		chk(direct_line_mode_r, 32'h1);
		chk(line_rate_bps_r, `DSULC_RATE_64K);
		chk(timing_src_r, 32'h1);
		line_u.ext_run = 1'b1;
		wr(`DSULC_CFG_OFS, 32'h0000_0ac1, 2'b00);
		commit();
		chk(line_rate_bps_r, `DSULC_RATE_56K);
		chk(timing_src_r, 32'h0);
		$display("test direct ended");
		wr(`DSULC_CFG_OFS, 32'h0000_0271, 2'b00);
		commit();
		chk(timing_src_r, 32'h2);
		wr(`DSULC_CMD_OFS, 32'h2, 2'b00);
		tick(2);
		chk(user_test_r, 32'h1);
		chk(timing_src_r, 32'h0);
		tick(25);
		chk(user_test_r, 32'h1);
		tick(25);
		chk(user_test_r, 32'h0);
		chk(timing_src_r, 32'h2);
		wr(`DSULC_CFG_OFS, 32'h0000_0231, 2'b00);
		wr(`DSULC_CMD_OFS, 32'h2, 2'b00);
		tick(100);
		chk(user_test_r, 32'h1);
		wr(`DSULC_CMD_OFS, 32'h4, 2'b00);
		tick(2);
		chk(user_test_r, 32'h0);
		$display("test timing ended");
		finish_test();
	end
endmodule : dsulc_top_tb_top
